// ### eight_bit_timer_counter_prescaler_tb_top.sv
// self-checking bench for the timer block: apb master tasks and scenarios.
// assumes tmc_pkg, tmc_timer and tmc_pin_src are compiled first.
`timescale 1ns/1ps
module eight_bit_timer_counter_prescaler_tb_top;
	import tmc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, irq, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          fail_count, compares;

	tmc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_count_pin(pin), .irq(irq));
	tmc_pin_src src (.pclk(pclk), .pin(pin));

	always #4 pclk = ~pclk;

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic bad(input string m);
		fail_count++;
		$display("BAD %0t %s", $time, m);
	endtask : bad

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) bad(m);
	endtask : chk

	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
		input logic [31:0] hi, input string m);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) bad(m);
	endtask : chk_rng

	// one full transfer; read data and error taken at the ready edge only
	task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w[0];
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad("no ready");
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic t_regs();
		apb(0, REG_OPTION, 0);
		chk(rd, 32'h0000_0000, "option reset");
		apb(0, REG_STATUS, 0);
		chk(rd, 32'h0000_0000, "status reset");
		apb(0, REG_MASK, 0);
		chk(rd, 32'h0000_0000, "mask reset");
		apb(0, REG_CTRL, 0);
		chk(rd, 32'h0000_0000, "ctrl reads zero");
		apb(0, 8'h18, 0);
		chk({31'h0, er}, 32'h0000_0001, "unmapped no error");
		apb(1, REG_OPTION, 32'h0000_003F);
		apb(0, REG_OPTION, 0);
		chk(rd, 32'h0000_003F, "option readback");
		$display("test regs done");
	endtask : t_regs

	task automatic t_timer();
		apb(1, REG_OPTION, 32'h0000_0008);
		apb(1, REG_COUNT, 32'h0000_0040);
		apb(0, REG_COUNT, 0);
		chk(rd, 32'h0000_0040, "count moved in hold off");
		repeat (80) @(posedge pclk);
		apb(0, REG_COUNT, 0);
		chk_rng(rd, 32'h0000_0052, 32'h0000_0055, "unscaled rate");
		$display("test timer done");
	endtask : t_timer

	task automatic t_presc();
		apb(1, REG_OPTION, 32'h0000_0002);
		apb(1, REG_COUNT, 32'h0000_0010);
		repeat (160) @(posedge pclk);
		apb(0, REG_COUNT, 0);
		chk_rng(rd, 32'h0000_0014, 32'h0000_0016, "ratio 1:8");
		apb(1, REG_OPTION, 32'h0000_0007);
		apb(1, REG_COUNT, 32'h0000_0010);
		repeat (160) @(posedge pclk);
		apb(0, REG_COUNT, 0);
		chk(rd, 32'h0000_0010, "ratio 1:256");
		$display("test prescaler done");
	endtask : t_presc

	task automatic t_irq();
		apb(1, REG_OPTION, 32'h0000_0008);
		apb(1, REG_MASK, 32'h0000_0001);
		apb(1, REG_STATUS, 32'h0000_0003);
		apb(1, REG_COUNT, 32'h0000_00FC);
		repeat (40) @(posedge pclk);
		apb(0, REG_STATUS, 0);
		chk({31'h0, rd[STAT_OVF]}, 32'h0000_0001, "no overflow flag");
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0001, "irq low");
		apb(1, REG_MASK, 0);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0000, "masked irq high");
		apb(1, REG_MASK, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0001, "unmasked irq low");
		apb(1, REG_STATUS, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0000, "irq after clear");
		apb(0, REG_STATUS, 0);
		chk({31'h0, rd[STAT_OVF]}, 32'h0000_0000, "flag not cleared");
		$display("test irq done");
	endtask : t_irq

	// three toggles give two rising edges from low, two falling from high
	task automatic t_count();
		apb(1, REG_OPTION, 32'h0000_0028);
		apb(1, REG_COUNT, 0);
		repeat (16) @(posedge pclk);
		src.toggle(3, 4);
		repeat (10) @(posedge pclk);
		apb(0, REG_COUNT, 0);
		chk(rd, 32'h0000_0002, "rising edge count");
		apb(1, REG_OPTION, 32'h0000_0038);
		apb(1, REG_COUNT, 0);
		repeat (16) @(posedge pclk);
		src.toggle(3, 4);
		repeat (10) @(posedge pclk);
		apb(0, REG_COUNT, 0);
		chk(rd, 32'h0000_0002, "falling edge count");
		$display("test counter done");
	endtask : t_count

	task automatic t_wdt();
		apb(1, REG_OPTION, 32'h0000_0008);
		repeat (40) @(posedge pclk);
		apb(1, REG_CTRL, 32'h0000_0001);
		apb(0, REG_WDT, 0);
		chk_rng(rd, 32'h0000_0000, 32'h0000_0002, "watchdog not cleared");
		// 1:1 owner: one wrap of 256 instruction cycles times out
		apb(1, REG_STATUS, 32'h0000_0002);
		repeat (1100) @(posedge pclk);
		apb(0, REG_STATUS, 0);
		chk({31'h0, rd[STAT_WDT]}, 32'h0000_0001, "no 1:1 watchdog timeout");
		// 1:2 owner: the first wrap must not time out, the second must
		apb(1, REG_OPTION, 32'h0000_0009);
		apb(1, REG_CTRL, 32'h0000_0001);
		apb(1, REG_STATUS, 32'h0000_0002);
		repeat (1100) @(posedge pclk);
		apb(0, REG_STATUS, 0);
		chk({31'h0, rd[STAT_WDT]}, 32'h0000_0000, "1:2 watchdog early");
		repeat (1100) @(posedge pclk);
		apb(0, REG_STATUS, 0);
		chk({31'h0, rd[STAT_WDT]}, 32'h0000_0001, "no 1:2 watchdog timeout");
		$display("test watchdog done");
	endtask : t_wdt

	initial begin
		pclk       = 1'b0;
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0000_0000;
		fail_count = 0;
		compares   = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_timer();
		t_presc();
		t_irq();
		t_count();
		t_wdt();
		print_verdict();
	end

	// cuts a hang short well inside the cycle budget
	initial begin
		repeat (100000) @(posedge pclk);
		bad("run timeout");
		print_verdict();
	end
endmodule : eight_bit_timer_counter_prescaler_tb_top

// ### tmc_edge_sync.sv
// edge synchroniser for the external count pin.
// assumes the pin is asynchronous to pclk and holds each level for at least three clocks.
`timescale 1ns/1ps
module tmc_edge_sync (
	input  wire logic pclk,     // system clock
	input  wire logic presetn,  // async reset, active low
	input  wire logic pin_in,   // raw external pin
	output logic      rise,     // one-cycle pulse on rising edge
	output logic      fall      // one-cycle pulse on falling edge
);
	logic s1_r, s2_r, s3_r;
	logic s1_nxt, s2_nxt, s3_nxt;

	always_comb begin
		s1_nxt = pin_in;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	// only the second and third stages feed the edge detect
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;

	a_sync_rise_delay: assert property (@(posedge pclk) disable iff (!presetn)
		rise |-> $past(pin_in, 2) && !$past(pin_in, 3))
		else $error("rise pulse not two cycles after pin rose");
endmodule : tmc_edge_sync

// ### tmc_pin_src.sv
// external count source model for the counter pin.
// assumes it runs on pclk; levels change just after rising edges.
`timescale 1ns/1ps
module tmc_pin_src #(
	parameter int MIN_HOLD = 3  // shortest level hold in pclk cycles
) (
	input  wire logic pclk, // system clock
	output logic      pin   // external count level
);
	initial pin = 1'b0;

	// never shorter than the synchroniser can sample, whatever is asked
	task automatic toggle(input int n, input int h);
		int k;
		k = (h < MIN_HOLD) ? MIN_HOLD : h;
		repeat (n) begin
			repeat (k) @(posedge pclk);
			pin <= ~pin;
		end
	endtask : toggle
endmodule : tmc_pin_src

// ### tmc_pkg.sv
// How it works
// - the counter is an 8-bit software readable and writable value that flags an overflow interrupt when it wraps from FFh to 00h.
// - with the source select bit (bit 5) clear the counter adds one every instruction cycle when it has no prescaler.
// - after any software write to the counter, increments are held off for the next two instruction cycles.
// - with the source select bit set the counter counts edges of the external count pin instead of instruction cycles.
// - in counter mode the edge select bit (bit 4) picks rising edges when clear and falling edges when set.
// - the external pin is synchronised to the internal clock and the increment lands a fixed delay after it; the source must be slow enough to be sampled.
// - one 8-bit prescaler serves either the counter or the watchdog, and the unit without it runs unscaled.
// - software has no read or write path to the prescaler count.
// - the prescaler assign bit and the three-bit ratio field sit in bits 3 to 0 of the option register.
// - with the assign bit clear the prescaler feeds the counter with ratios 1:2 up to 1:256 in powers of two.
// - with the assign bit set the prescaler is the watchdog postscaler with ratios 1:1 up to 1:128 in powers of two.
// - while the counter owns the prescaler, every counter write clears the prescale count and leaves the assign bit alone.
// - while the watchdog owns the prescaler, the watchdog clear instruction resets both the prescale count and the watchdog counter.
//
// package: register map, field positions, reset values and timing for the timer block.
// assumes a 32-bit apb master and one clock; the instruction cycle is a divided enable.
package tmc_pkg;
	localparam int         APB_AW         = 8;
	localparam int         APB_DW         = 32;
	localparam int         CNT_W          = 8;
	localparam int         PSC_W          = 8;
	localparam int         PS_W           = 3;

	localparam logic [7:0] REG_COUNT      = 8'h00;
	localparam logic [7:0] REG_OPTION     = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_MASK       = 8'h0C;
	localparam logic [7:0] REG_CTRL       = 8'h10;
	localparam logic [7:0] REG_WDT        = 8'h14;

	localparam int         OPT_CS         = 5;
	localparam int         OPT_SE         = 4;
	localparam int         OPT_ASSIGN     = 3;
	localparam int         OPT_PS_LSB     = 0;
	localparam int         OPT_W          = 6;
	localparam logic [5:0] OPTION_RST     = 6'h00;

	localparam int         STAT_OVF       = 0;
	localparam int         STAT_WDT       = 1;
	localparam int         STAT_W         = 2;
	localparam logic [1:0] STATUS_RST     = 2'h0;
	localparam logic [1:0] MASK_RST       = 2'h0;
	localparam int         CTRL_WCLR      = 0;

	localparam logic [7:0] CNT_RST        = 8'h00;
	localparam logic [7:0] CNT_MAX        = 8'hFF;
	localparam int         INSTR_DIV      = 4;
	localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
endpackage : tmc_pkg

// ### tmc_prescaler.sv
// shared 8-bit prescaler; divides an input tick by a power of two.
// assumes tick_in is a one-cycle pulse and clear is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module tmc_prescaler import tmc_pkg::*; #(
	parameter int W = tmc_pkg::PSC_W   // prescale counter width
) (
	input  wire logic                    pclk,      // system clock
	input  wire logic                    presetn,   // async reset, active low
	input  wire logic                    tick_in,   // undivided tick
	input  wire logic                    clear,     // clear the count
	input  wire logic                    to_wdt,    // owner is the watchdog
	input  wire logic [tmc_pkg::PS_W-1:0] ratio,    // ratio field
	output logic                         tick_out   // divided tick
);
	logic [W-1:0] cnt_r, cnt_nxt;
	logic [W-1:0] mask;

	// low bits that must be all ones before a tick passes
	function automatic logic [W-1:0] ratio_mask(input logic [PS_W-1:0] n, input logic wdt);
		logic [3:0] k;
		k = wdt ? {1'b0, n} : ({1'b0, n} + 4'h1);
		ratio_mask = W'((9'h001 << k) - 9'h001);
	endfunction : ratio_mask

	always_comb begin
		mask     = ratio_mask(ratio, to_wdt);
		tick_out = tick_in & ~clear & ((cnt_r & mask) == mask);
		cnt_nxt  = cnt_r;
		if (clear)
			cnt_nxt = '0;
		else if (tick_in)
			cnt_nxt = cnt_r + W'(1);
	end

	// count has no software path in or out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	a_psc_clear: assert property (@(posedge pclk) disable iff (!presetn)
		clear |=> cnt_r == '0)
		else $error("prescale count not cleared");
	a_psc_ratio: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_out && !to_wdt && ratio == 3'h0) |-> cnt_r[0])
		else $error("1:2 ratio passed tick on even count");
	a_psc_wdt_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_in && !clear && to_wdt && ratio == 3'h0) |-> tick_out)
		else $error("1:1 watchdog ratio dropped a tick");
endmodule : tmc_prescaler

// ### tmc_timer.sv
// 8-bit timer/counter with shared prescaler, watchdog counter and apb register slave.
// assumes apb master on pclk; external_count_pin is asynchronous.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module tmc_timer #(
	parameter int INSTR_DIV = tmc_pkg::INSTR_DIV  // pclk cycles per instruction cycle
) (
	input  wire logic                        pclk,               // system clock
	input  wire logic                        presetn,            // async reset, active low
	input  wire logic                        psel,               // apb select
	input  wire logic                        penable,            // apb enable
	input  wire logic                        pwrite,             // apb write
	input  wire logic [tmc_pkg::APB_AW-1:0]  paddr,              // apb byte address
	input  wire logic [tmc_pkg::APB_DW-1:0]  pwdata,             // apb write data
	output logic      [tmc_pkg::APB_DW-1:0]  prdata,             // apb read data
	output logic                             pready,             // apb ready
	output logic                             pslverr,            // apb error on unmapped
	input  wire logic                        external_count_pin, // external count source
	output logic                             irq                 // level interrupt
);
	import tmc_pkg::*;

	// instruction cycle enable
	logic [1:0]        div_r, div_nxt;
	logic              instr_en_r, instr_en_nxt;

	// software visible state and the write hold off count
	logic [CNT_W-1:0]  counter_value_reg_r, counter_value_reg_nxt;
	logic [OPT_W-1:0]  option_r, option_nxt;
	logic [STAT_W-1:0] status_r, status_nxt;
	logic [STAT_W-1:0] mask_r, mask_nxt;
	logic [CNT_W-1:0]  wdt_cnt_r, wdt_cnt_nxt;
	logic [1:0]        inhibit_r, inhibit_nxt;

	// bus answer and interrupt output
	logic [APB_DW-1:0] prdata_r, prdata_nxt;
	logic              pready_r, pready_nxt;
	logic              pslverr_r, pslverr_nxt;
	logic              irq_r, irq_nxt;

	// datapath terms
	logic              acc, wr_acc, rd_phase;
	logic              cnt_wr, wclr;
	logic              rise, fall, ext_edge, src_tick;
	logic              count_source_select, count_edge_select, prescaler_assign;
	logic [PS_W-1:0]   prescale_ratio_field;
	logic              wdt_wrap, psc_in, psc_clr, psc_out;
	logic              inc_raw, inc_en, ovf, wdt_event;
	logic [STAT_W-1:0] ev, w1c;

	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		if (a == REG_COUNT)       is_mapped = 1'b1;
		else if (a == REG_OPTION) is_mapped = 1'b1;
		else if (a == REG_STATUS) is_mapped = 1'b1;
		else if (a == REG_MASK)   is_mapped = 1'b1;
		else if (a == REG_CTRL)   is_mapped = 1'b1;
		else if (a == REG_WDT)    is_mapped = 1'b1;
		else                      is_mapped = 1'b0;
	endfunction : is_mapped

	tmc_edge_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (external_count_pin),
		.rise    (rise),
		.fall    (fall)
	);

	tmc_prescaler #(.W(PSC_W)) u_psc (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (psc_in),
		.clear    (psc_clr),
		.to_wdt   (prescaler_assign),
		.ratio    (prescale_ratio_field),
		.tick_out (psc_out)
	);

	// option field split
	always_comb begin
		count_source_select  = option_r[OPT_CS];
		count_edge_select    = option_r[OPT_SE];
		prescaler_assign     = option_r[OPT_ASSIGN];
		prescale_ratio_field = option_r[OPT_PS_LSB +: PS_W];
	end

	// apb phase decode
	always_comb begin
		acc      = psel & penable & pready_r;
		wr_acc   = acc & pwrite;
		rd_phase = psel & penable & ~pready_r;
		cnt_wr   = wr_acc & (paddr == REG_COUNT);
		wclr     = wr_acc & (paddr == REG_CTRL) & pwdata[CTRL_WCLR];
		w1c      = (wr_acc & (paddr == REG_STATUS)) ? pwdata[STAT_W-1:0] : '0;
	end

	// count path and prescaler routing
	always_comb begin
		ext_edge  = count_edge_select ? fall : rise;
		src_tick  = count_source_select ? ext_edge : instr_en_r;
		wdt_wrap  = instr_en_r & (wdt_cnt_r == CNT_MAX);
		psc_in    = prescaler_assign ? wdt_wrap : src_tick;
		psc_clr   = prescaler_assign ? wclr : cnt_wr;
		inc_raw   = prescaler_assign ? src_tick : psc_out;
		inc_en    = inc_raw & (inhibit_r == 2'h0) & ~cnt_wr;
		ovf       = inc_en & (counter_value_reg_r == CNT_MAX);
		wdt_event = prescaler_assign ? psc_out : wdt_wrap;
		ev        = '0;
		ev[STAT_OVF] = ovf;
		ev[STAT_WDT] = wdt_event;
	end

	// instruction cycle divider
	always_comb begin
		instr_en_nxt = (div_r == 2'(INSTR_DIV - 1));
		div_nxt      = instr_en_nxt ? 2'h0 : div_r + 2'h1;
	end

	// counter, watchdog, inhibit and control registers
	always_comb begin
		counter_value_reg_nxt = counter_value_reg_r;
		option_nxt            = option_r;
		mask_nxt              = mask_r;
		wdt_cnt_nxt           = wdt_cnt_r;
		inhibit_nxt           = inhibit_r;
		if (cnt_wr)
			counter_value_reg_nxt = pwdata[CNT_W-1:0];
		else if (inc_en)
			counter_value_reg_nxt = counter_value_reg_r + 8'h01;
		if (cnt_wr)
			inhibit_nxt = INHIBIT_CYCLES;
		else if (instr_en_r && inhibit_r != 2'h0)
			inhibit_nxt = inhibit_r - 2'h1;
		if (wclr)
			wdt_cnt_nxt = CNT_RST;
		else if (instr_en_r)
			wdt_cnt_nxt = wdt_cnt_r + 8'h01;
		// counter writes never touch the option register
		if (wr_acc && paddr == REG_OPTION)
			option_nxt = pwdata[OPT_W-1:0];
		if (wr_acc && paddr == REG_MASK)
			mask_nxt = pwdata[STAT_W-1:0];
		// a new event beats a same-cycle clear
		status_nxt = (status_r & ~w1c) | ev;
		irq_nxt    = |(status_nxt & mask_nxt);
	end

	// read mux and bus answer; one wait state before pready
	always_comb begin
		pready_nxt  = rd_phase;
		prdata_nxt  = '0;
		pslverr_nxt = 1'b0;
		if (rd_phase) begin
			pslverr_nxt = ~is_mapped(paddr);
			if (!pwrite) begin
				if (paddr == REG_COUNT)
					prdata_nxt = {24'h00_0000, counter_value_reg_r};
				else if (paddr == REG_OPTION)
					prdata_nxt = {26'h000_0000, option_r};
				else if (paddr == REG_STATUS)
					prdata_nxt = {30'h0000_0000, status_r};
				else if (paddr == REG_MASK)
					prdata_nxt = {30'h0000_0000, mask_r};
				else if (paddr == REG_WDT)
					prdata_nxt = {24'h00_0000, wdt_cnt_r};
				else
					prdata_nxt = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r               <= 2'h0;
			instr_en_r          <= 1'b0;
			counter_value_reg_r <= CNT_RST;
			option_r            <= OPTION_RST;
			status_r            <= STATUS_RST;
			mask_r              <= MASK_RST;
			wdt_cnt_r           <= CNT_RST;
			inhibit_r           <= 2'h0;
			prdata_r            <= '0;
			pready_r            <= 1'b0;
			pslverr_r           <= 1'b0;
			irq_r               <= 1'b0;
		end else begin
			div_r               <= div_nxt;
			instr_en_r          <= instr_en_nxt;
			counter_value_reg_r <= counter_value_reg_nxt;
			option_r            <= option_nxt;
			status_r            <= status_nxt;
			mask_r              <= mask_nxt;
			wdt_cnt_r           <= wdt_cnt_nxt;
			inhibit_r           <= inhibit_nxt;
			prdata_r            <= prdata_nxt;
			pready_r            <= pready_nxt;
			pslverr_r           <= pslverr_nxt;
			irq_r               <= irq_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ovf_sets_flag: assert property (
		(inc_en && counter_value_reg_r == 8'hFF) |=> status_r[STAT_OVF] && counter_value_reg_r == 8'h00)
		else $error("wrap did not set overflow flag");

	a_timer_step: assert property (
		(!count_source_select && prescaler_assign && instr_en_r && inhibit_r == 2'h0 && !cnt_wr)
		|=> counter_value_reg_r == $past(counter_value_reg_r) + 8'h01)
		else $error("timer mode missed an instruction cycle");

	a_write_holdoff: assert property (
		cnt_wr |=> inhibit_r == 2'h2 && !inc_en)
		else $error("count not held after write");

	a_holdoff_gate: assert property (
		(inhibit_r != 2'h0) |-> counter_value_reg_r == $past(counter_value_reg_r) || $past(cnt_wr))
		else $error("count moved during hold off");

	a_counter_source: assert property (
		(count_source_select && prescaler_assign && inc_en) |-> (rise || fall) && !$past(cnt_wr))
		else $error("counter mode stepped without pin edge");

	a_edge_choice: assert property (
		(count_source_select && prescaler_assign && inc_en) |-> (count_edge_select ? fall : rise))
		else $error("counted the wrong pin edge");

	a_sync_latency: assert property (
		(count_source_select && prescaler_assign && inc_en)
		|-> $past(external_count_pin, 2) != $past(external_count_pin, 3))
		else $error("pin edge reached counter without sync delay");

	a_psc_exclusive: assert property (
		prescaler_assign |-> inc_raw == src_tick && (wdt_event == psc_out))
		else $error("prescaler shared by both units");

	a_wdt_unscaled: assert property (
		(!prescaler_assign && wdt_wrap) |-> wdt_event)
		else $error("watchdog scaled while prescaler serves counter");

	a_wclr_both: assert property (
		(wclr && prescaler_assign) |=> wdt_cnt_r == 8'h00 && !wdt_event)
		else $error("watchdog clear missed counter");

	a_option_kept: assert property (
		cnt_wr |=> option_r == $past(option_r))
		else $error("counter write changed assignment");

	a_irq_level: assert property (
		irq_r == |(status_r & mask_r))
		else $error("irq does not follow masked status");

	// bus handshake: one wait state, every answer stands one cycle
	a_pready_wait: assert property (
		(psel && penable && !pready_r) |=> pready_r)
		else $error("no ready after the wait state");

	a_pready_pulse: assert property (
		pready_r |=> !pready_r)
		else $error("ready stood longer than one cycle");

	a_slverr_ready: assert property (
		pslverr_r |-> pready_r)
		else $error("error response without ready");

	a_unmapped_err: assert property (
		(rd_phase && !is_mapped(paddr)) |=> pslverr_r)
		else $error("unmapped access gave no error");

	a_prdata_idle: assert property (
		!pready_r |-> prdata_r == '0)
		else $error("read data not zero outside ready");

	a_ctrl_reads_zero: assert property (
		(rd_phase && !pwrite && paddr == REG_CTRL) |=> prdata_r == '0)
		else $error("control register read not zero");

	// register writes and sticky flags
	a_unmapped_ignored: assert property (
		(wr_acc && !is_mapped(paddr))
		|=> option_r == $past(option_r) && mask_r == $past(mask_r))
		else $error("unmapped write changed a register");

	a_option_write: assert property (
		(wr_acc && paddr == REG_OPTION)
		|=> {26'h000_0000, option_r} == ($past(pwdata) & 32'h0000_003F))
		else $error("option write not taken");

	a_mask_write: assert property (
		(wr_acc && paddr == REG_MASK)
		|=> {30'h0000_0000, mask_r} == ($past(pwdata) & 32'h0000_0003))
		else $error("mask write not taken");

	a_status_sticky: assert property (
		(status_r[STAT_OVF] && !w1c[STAT_OVF]) |=> status_r[STAT_OVF])
		else $error("overflow flag dropped without a clear");

	a_w1c_clears: assert property (
		(w1c[STAT_OVF] && !ev[STAT_OVF]) |=> !status_r[STAT_OVF])
		else $error("overflow flag not cleared by write of one");

	a_ovf_only_wrap: assert property (
		$rose(status_r[STAT_OVF]) |-> $past(ovf))
		else $error("overflow flag set without a wrap");

	a_wdt_flag_set: assert property (
		ev[STAT_WDT] |=> status_r[STAT_WDT])
		else $error("watchdog event did not set its flag");

	// counter, hold off and watchdog
	a_count_load: assert property (
		cnt_wr |=> {24'h00_0000, counter_value_reg_r} == ($past(pwdata) & 32'h0000_00FF))
		else $error("counter write not loaded");

	a_count_still: assert property (
		(!inc_en && !cnt_wr) |=> counter_value_reg_r == $past(counter_value_reg_r))
		else $error("counter moved without an increment");

	a_inhibit_step: assert property (
		(instr_en_r && inhibit_r != 2'h0 && !cnt_wr) |=> inhibit_r == $past(inhibit_r) - 2'h1)
		else $error("hold off did not count instruction cycles");

	a_instr_phase: assert property (
		instr_en_r |-> div_r == 2'h0)
		else $error("instruction pulse out of divider phase");

	a_timer_prescaled: assert property (
		(!count_source_select && !prescaler_assign && inc_en) |-> instr_en_r)
		else $error("prescaled timer stepped off an instruction cycle");

	a_wdt_step: assert property (
		(instr_en_r && !wclr) |=> wdt_cnt_r == $past(wdt_cnt_r) + 8'h01)
		else $error("watchdog missed an instruction cycle");

	a_wdt_clear: assert property (
		wclr |=> wdt_cnt_r == 8'h00)
		else $error("watchdog clear left a count");
endmodule : tmc_timer
